// file: tmr8_wave.sv
/*
  8-bit timer counter with compare unit and waveform generator.
  Holds control, count, compare and flag registers on a plain
  register port with read data one cycle after the read strobe.
  Assumes port value and direction bit come from mclk logic, and the
  interrupt acknowledges are one-cycle pulses on mclk.
*/
`default_nettype none
module tmr8_wave (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  input  wire logic       port_out_value,
  input  wire logic       compare_pin_direction_bit,
  input  wire logic       ovf_int_ack,
  input  wire logic       cmp_int_ack,
  output var  logic       pin_out,
  output var  logic       pin_oe_n,
  output var  logic       overflow_flag,
  output var  logic       compare_match_flag,
  output var  logic       compare_output_state
);

  typedef struct packed {
    logic [7:0] counter_value;
    logic [7:0] cmp_active;
    logic [7:0] compare_value;
    logic [1:0] waveform_mode_select;
    logic [1:0] compare_output_action;
    logic [2:0] clk_sel;
    logic       ocs;
    logic       ovf;
    logic       ocf;
    logic       block;
    logic [7:0] rdata;
  } tmr8_state_t;

  tmr8_state_t st_reg;
  tmr8_state_t st_next;

  tmr8_pre_if pre_link ();

  tmr8_prescale u_pre (
    .mclk  (mclk),
    .reset (reset),
    .pre   (pre_link)
  );

  assign pre_link.clk_sel = st_reg.clk_sel;

  logic       tick;
  logic       is_pwm;
  logic       at_max;
  logic       match;
  logic       wr_ctrl;
  logic       wr_cnt;
  logic       wr_cmp;
  logic       wr_flg;
  logic [1:0] new_act;
  logic       force_hit;

  assign tick    = pre_link.tick;
  assign is_pwm  = st_reg.waveform_mode_select[0];
  assign at_max  = (st_reg.counter_value == tmr8_pkg::CNT_MAX);
  // Counter write blocks the match of the next tick
  assign match   = (st_reg.counter_value == st_reg.cmp_active)
                 && !st_reg.block;
  assign wr_ctrl = reg_wr && (reg_addr == tmr8_pkg::ADDR_CTRL);
  assign wr_cnt  = reg_wr && (reg_addr == tmr8_pkg::ADDR_COUNT);
  assign wr_cmp  = reg_wr && (reg_addr == tmr8_pkg::ADDR_CMP);
  assign wr_flg  = reg_wr && (reg_addr == tmr8_pkg::ADDR_FLAGS);
  assign new_act = reg_wdata[tmr8_pkg::CTRL_ACT_LSB +: 2];
  assign force_hit = wr_ctrl
                   && reg_wdata[tmr8_pkg::CTRL_FORCE_BIT]
                   && !reg_wdata[tmr8_pkg::CTRL_MODE_LSB];

  // Apply a non-PWM action to the output state
  function automatic logic apply_act(
    input logic [1:0] act,
    input logic       cur
  );
    logic r;
    r = cur;
    case (act)
      tmr8_pkg::TMR8_ACT_TOGGLE: r = !cur;
      tmr8_pkg::TMR8_ACT_CLEAR:  r = 1'b0;
      tmr8_pkg::TMR8_ACT_SET:    r = 1'b1;
      default:                   r = cur;
    endcase
    return r;
  endfunction

  always_comb begin
    st_next = st_reg;

    // Timer tick: counting, flags and waveform
    if (tick) begin
      st_next.block = 1'b0;

      case (st_reg.waveform_mode_select)
        tmr8_pkg::TMR8_CLEAR: begin
          if (match) begin
            st_next.counter_value = tmr8_pkg::CNT_BOTTOM;
          end else begin
            // Low compare misses, count runs on to wrap
            st_next.counter_value =
              st_reg.counter_value + 8'h01;
          end
        end
        tmr8_pkg::TMR8_FAST: begin
          if (at_max) begin
            st_next.counter_value = tmr8_pkg::CNT_BOTTOM;
          end else begin
            st_next.counter_value =
              st_reg.counter_value + 8'h01;
          end
        end
        default: begin
          // Up count wrapping at maximum, no hardware clear
          st_next.counter_value =
            st_reg.counter_value + 8'h01;
        end
      endcase

      // Overflow on the step from maximum to zero
      if (at_max) begin
        st_next.ovf = 1'b1;
      end

      // Compare flag one tick after the count equals compare
      if (match) begin
        st_next.ocf = 1'b1;
      end

      // Waveform generation
      if (!is_pwm) begin
        if (match) begin
          st_next.ocs = apply_act(st_reg.compare_output_action,
                                  st_reg.ocs);
        end
      end else begin
        case (st_reg.compare_output_action)
          tmr8_pkg::TMR8_ACT_CLEAR: begin
            if (match) begin
              st_next.ocs = 1'b0;
            end else if (at_max) begin
              st_next.ocs = 1'b1;
            end
          end
          tmr8_pkg::TMR8_ACT_SET: begin
            if (match) begin
              st_next.ocs = 1'b1;
            end else if (at_max) begin
              st_next.ocs = 1'b0;
            end
          end
          tmr8_pkg::TMR8_ACT_TOGGLE: begin
            if (match) begin
              st_next.ocs = !st_reg.ocs;
            end
          end
          default: begin
            st_next.ocs = st_reg.ocs;
          end
        endcase
        // Buffered compare loads at the wrap to bottom
        if (at_max) begin
          st_next.cmp_active = st_reg.compare_value;
        end
      end
    end

    // Processor writes
    if (wr_ctrl) begin
      st_next.waveform_mode_select =
        reg_wdata[tmr8_pkg::CTRL_MODE_LSB +: 2];
      // Stored for the next match; a force write outside PWM applies it at once
      st_next.compare_output_action = new_act;
      st_next.clk_sel = reg_wdata[tmr8_pkg::CTRL_CSEL_LSB +: 3];
    end
    if (force_hit) begin
      st_next.ocs = apply_act(new_act, st_reg.ocs);
    end
    if (wr_cnt) begin
      // Write wins over count and clear in any state
      st_next.counter_value = reg_wdata;
      st_next.block = 1'b1;
    end
    if (wr_cmp) begin
      st_next.compare_value = reg_wdata;
      if (!is_pwm) begin
        st_next.cmp_active = reg_wdata;
      end
    end

    // Flag clearing, a same-cycle set wins
    if ((wr_flg && reg_wdata[tmr8_pkg::FLAG_OVF_BIT]) || ovf_int_ack) begin
      if (!(tick && at_max)) begin
        st_next.ovf = 1'b0;
      end
    end
    if ((wr_flg && reg_wdata[tmr8_pkg::FLAG_CMP_BIT]) || cmp_int_ack) begin
      if (!(tick && match)) begin
        st_next.ocf = 1'b0;
      end
    end

    // Register read, data one cycle later
    st_next.rdata = tmr8_pkg::RESET_BYTE;
    if (reg_rd) begin
      if (reg_addr == tmr8_pkg::ADDR_CTRL) begin
        st_next.rdata = {1'b0,
                         st_reg.clk_sel,
                         st_reg.compare_output_action,
                         st_reg.waveform_mode_select};
      end else if (reg_addr == tmr8_pkg::ADDR_COUNT) begin
        st_next.rdata = st_reg.counter_value;
      end else if (reg_addr == tmr8_pkg::ADDR_CMP) begin
        st_next.rdata = st_reg.compare_value;
      end else begin
        st_next.rdata = {6'h00, st_reg.ocf, st_reg.ovf};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_reg.counter_value         <= tmr8_pkg::RESET_BYTE;
      st_reg.cmp_active            <= tmr8_pkg::RESET_BYTE;
      st_reg.compare_value         <= tmr8_pkg::RESET_BYTE;
      st_reg.waveform_mode_select  <= 2'h0;
      st_reg.compare_output_action <= 2'h0;
      st_reg.clk_sel               <= 3'h0;
      st_reg.ocs                   <= 1'b0;
      st_reg.ovf                   <= 1'b0;
      st_reg.ocf                   <= 1'b0;
      st_reg.block                 <= 1'b0;
      st_reg.rdata                 <= tmr8_pkg::RESET_BYTE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Pin takeover by the action field alone
  always_comb begin
    if (st_reg.compare_output_action != 2'h0) begin
      pin_out = st_reg.ocs;
    end else begin
      pin_out = port_out_value;
    end
    pin_oe_n = !compare_pin_direction_bit;
  end

  assign reg_rdata            = st_reg.rdata;
  assign overflow_flag        = st_reg.ovf;
  assign compare_match_flag   = st_reg.ocf;
  assign compare_output_state = st_reg.ocs;

endmodule
`default_nettype wire

// file: tmr8_pkg.sv
/*
  Constants, register map and types of the 8-bit timer waveform block.
  Assumes one system clock and a plain register port on the processor side.
*/
`default_nettype none
package tmr8_pkg;
  localparam logic [1:0] ADDR_CTRL  = 2'h0;
  localparam logic [1:0] ADDR_COUNT = 2'h1;
  localparam logic [1:0] ADDR_CMP   = 2'h2;
  localparam logic [1:0] ADDR_FLAGS = 2'h3;
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_ACT_LSB   = 2;
  localparam int CTRL_CSEL_LSB  = 4;
  localparam int CTRL_FORCE_BIT = 7;
  localparam int FLAG_OVF_BIT   = 0;
  localparam int FLAG_CMP_BIT   = 1;
  localparam logic [7:0] CNT_MAX    = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [9:0] PRE_RESET  = 10'h000;
  typedef enum logic [1:0] {
    TMR8_NORMAL = 2'h0,
    TMR8_PHASE  = 2'h1,
    TMR8_CLEAR  = 2'h2,
    TMR8_FAST   = 2'h3
  } tmr8_mode_t;
  typedef enum logic [1:0] {
    TMR8_ACT_NONE   = 2'h0,
    TMR8_ACT_TOGGLE = 2'h1,
    TMR8_ACT_CLEAR  = 2'h2,
    TMR8_ACT_SET    = 2'h3
  } tmr8_act_t;
  // Prescaler terminal masks per clock select, 0 means stopped
  localparam logic [9:0] DIV1_MASK    = 10'h000;
  localparam logic [9:0] DIV8_MASK    = 10'h007;
  localparam logic [9:0] DIV32_MASK   = 10'h01f;
  localparam logic [9:0] DIV64_MASK   = 10'h03f;
  localparam logic [9:0] DIV128_MASK  = 10'h07f;
  localparam logic [9:0] DIV256_MASK  = 10'h0ff;
  localparam logic [9:0] DIV1024_MASK = 10'h3ff;
endpackage
`default_nettype wire

// file: tmr8_pre_if.sv
/*
  Link between the timer core and its prescaler.
  Assumes both ends share the system clock.
*/
`default_nettype none
interface tmr8_pre_if;
  logic [2:0] clk_sel;
  logic       tick;
  modport core (output clk_sel, input tick);
  modport pre  (input clk_sel, output tick);
endinterface
`default_nettype wire

// file: tmr8_prescale.sv
/*
  Prescaler producing the timer tick enable from the system clock.
  Assumes synchronous active-high reset on mclk.
*/
`default_nettype none
module tmr8_prescale (
  input  wire logic mclk,
  input  wire logic reset,
  tmr8_pre_if.pre   pre
);
  typedef struct packed {
    logic [9:0] cnt;
  } tmr8_pre_state_t;
  tmr8_pre_state_t st_reg;
  tmr8_pre_state_t st_next;
  logic [9:0] mask;
  always_comb begin
    case (pre.clk_sel)
      3'h1: mask = tmr8_pkg::DIV1_MASK;
      3'h2: mask = tmr8_pkg::DIV8_MASK;
      3'h3: mask = tmr8_pkg::DIV32_MASK;
      3'h4: mask = tmr8_pkg::DIV64_MASK;
      3'h5: mask = tmr8_pkg::DIV128_MASK;
      3'h6: mask = tmr8_pkg::DIV256_MASK;
      default: mask = tmr8_pkg::DIV1024_MASK;
    endcase
  end
  // Tick when the low bits of the free count all reach one
  assign pre.tick = (pre.clk_sel != 3'h0)
                  && ((st_reg.cnt & mask) == mask);
  always_comb begin
    st_next = st_reg;
    st_next.cnt = st_reg.cnt + 10'h001;
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_reg.cnt <= tmr8_pkg::PRE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

// file: tmr8_wave_properties.sv
/*
  Port checker of the 8-bit timer waveform block.
  Assumes it is bound to tmr8_wave and sees only its ports.
*/
`default_nettype none
module tmr8_wave_props (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       port_out_value,
  input wire logic       compare_pin_direction_bit,
  input wire logic       ovf_int_ack,
  input wire logic       cmp_int_ack,
  input wire logic       pin_out,
  input wire logic       pin_oe_n,
  input wire logic       overflow_flag,
  input wire logic       compare_match_flag,
  input wire logic       compare_output_state
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] act_reg;
  logic [2:0] csel_reg;
  logic       ctl_wr;
  logic       ovf_clr;
  logic       cmp_clr;
  assign ctl_wr  = reg_wr && reg_addr == 2'h0;
  assign ovf_clr = ovf_int_ack || (reg_wr && reg_addr == 2'h3 && reg_wdata[0]);
  assign cmp_clr = cmp_int_ack || (reg_wr && reg_addr == 2'h3 && reg_wdata[1]);
  // Shadow of the action and clock select fields
  always_ff @(posedge mclk) begin
    if (reset) begin
      act_reg  <= 2'h0;
      csel_reg <= 3'h0;
    end else if (ctl_wr) begin
      act_reg  <= reg_wdata[3:2];
      csel_reg <= reg_wdata[6:4];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence force_wr;
    ctl_wr && reg_wdata[7] && csel_reg == 3'h0 && reg_wdata[6:4] == 3'h0;
  endsequence
  oe_from_dir_a: assert property (
    pin_oe_n == !compare_pin_direction_bit) else $error("enable mismatch");
  pin_source_a: assert property (
    pin_out == (act_reg != 2'h0 ? compare_output_state : port_out_value))
    else $error("pin source mismatch");
  act_zero_hold_a: assert property (
    act_reg == 2'h0 && !ctl_wr |=> $stable(compare_output_state))
    else $error("state moved with no action");
  stopped_quiet_a: assert property (
    csel_reg == 3'h0 && !ctl_wr |=> !$rose(overflow_flag)
    && !$rose(compare_match_flag) && $stable(compare_output_state))
    else $error("change while stopped");
  ovf_clear_a: assert property (
    $fell(overflow_flag) |-> $past(ovf_clr)) else $error("overflow lost");
  cmp_clear_a: assert property (
    $fell(compare_match_flag) |-> $past(cmp_clr)) else $error("match lost");
  force_set_a: assert property (
    force_wr ##0 (!reg_wdata[0] && reg_wdata[3:2] == 2'h3)
    |=> compare_output_state) else $error("force set failed");
  force_clear_a: assert property (
    force_wr ##0 (!reg_wdata[0] && reg_wdata[3:2] == 2'h2)
    |=> !compare_output_state) else $error("force clear failed");
  force_toggle_a: assert property (
    force_wr ##0 (!reg_wdata[0] && reg_wdata[3:2] == 2'h1)
    |=> compare_output_state != $past(compare_output_state))
    else $error("force toggle failed");
  pwm_no_force_a: assert property (
    force_wr ##0 reg_wdata[0] |=> $stable(compare_output_state))
    else $error("force acted in pwm");
endmodule
bind tmr8_wave tmr8_wave_props chk (.mclk, .reset, .reg_addr, .reg_wdata,
  .reg_wr, .port_out_value, .compare_pin_direction_bit, .ovf_int_ack,
  .cmp_int_ack, .pin_out, .pin_oe_n, .overflow_flag, .compare_match_flag,
  .compare_output_state);
`default_nettype wire

// file: tmr8_pin_load.sv
/*
  External load on the compare output pin.
  Assumes a pull-up holds the line while the pin is released.
*/
`default_nettype none
module tmr8_pin_load (
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output var  logic pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pin_level = pin_oe_n ? 1'b1 : pin_out;
endmodule
`default_nettype wire

// file: tmr8_wave_tb_top.sv
/*
  Self-checking bench of the 8-bit timer waveform block.
  Assumes the checker is bound in and the pin load model is present.
*/
`default_nettype none
module tmr8_wave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, reset, reg_wr, reg_rd, port_out_value, dir, o_ack, c_ack;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic       pin_out, pin_oe_n, ovf, cmpf, ocs, pin_level;
  integer     seed = 32'haefffe45;
  int         err_total, total_checks, n, m, c, k;
  int         divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [7:0] fv[5] = '{8'h8c, 8'h88, 8'h84, 8'h80, 8'h8b};
  logic       ev[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  tmr8_wave dut (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .port_out_value, .compare_pin_direction_bit(dir),
    .ovf_int_ack(o_ack), .cmp_int_ack(c_ack), .pin_out, .pin_oe_n,
    .overflow_flag(ovf), .compare_match_flag(cmpf),
    .compare_output_state(ocs));
  tmr8_pin_load load (.pin_out, .pin_oe_n, .pin_level);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    port_out_value <= 1'($random(seed));
    dir <= 1'($random(seed));
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic wait_ocs(output int w);
    logic s;
    s = ocs;
    w = 0;
    do begin
      @(posedge mclk);
      #1;
      w++;
    end while (ocs === s && w < 20000);
  endtask
  task automatic chk1(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: bit %b not %b", $time, g, e);
    end
  endtask
  task automatic chkn(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: %0d cycles not %0d", $time, g, e);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #500_000;
    err_total++;
    end_sim;
  end
  initial begin
    {reset, reg_wr, reg_rd, o_ack, c_ack} = 5'h10;
    {reg_addr, reg_wdata} = '0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    for (k = 0; k < 4; k++) begin
      rd(2'(k), v);
      chkn({24'h000000, v}, 32'h0);
    end
    // Forced actions with the timer stopped, then the pin source
    for (k = 0; k < 5; k++) begin
      wr(2'h0, fv[k]);
      chk1(ocs, ev[k]);
      chk1(pin_level, !dir ? 1'b1 : (fv[k][3:2] != 2'h0 ? ev[k]
        : port_out_value));
    end
    // Normal mode: counter writes and overflow timing
    wr(2'h0, 8'h10);
    for (k = 0; k < 4; k++) begin
      if (k[0]) wr(2'h3, 8'h01);
      else begin
        @(posedge mclk) o_ack <= 1'b1;
        @(posedge mclk) o_ack <= 1'b0;
      end
      v = {4'hf, 4'($random(seed))};
      wr(2'h1, v);
      for (n = 1; n < 300 && ovf !== 1'b1; n++) @(posedge mclk) #1;
      chkn(n - 1, 256 - int'(v));
    end
    // Clear on match toggle period for every prescale factor
    for (k = 1; k < 8; k++) begin
      c = {$random(seed)} % 6 + 1;
      wr(2'h0, 8'h00);
      if (k[0]) wr(2'h3, 8'h02);
      else begin
        @(posedge mclk) c_ack <= 1'b1;
        @(posedge mclk) c_ack <= 1'b0;
      end
      wr(2'h1, 8'h00);
      chk1(cmpf, 1'b0);
      wr(2'h2, 8'(c));
      wr(2'h0, {1'b0, 3'(k), 4'h6});
      wait_ocs(n);
      wait_ocs(n);
      chkn(n, divs[k] * (c + 1));
      chk1(cmpf, 1'b1);
    end
    // Compare written below the count wraps through the maximum
    wr(2'h2, 8'h05);
    rd(2'h2, v);
    chkn({24'h000000, v}, 32'h5);
    wr(2'h0, 8'h12);
    wr(2'h1, 8'h20);
    wr(2'h3, 8'h02);
    for (n = 0; n < 400 && cmpf !== 1'b1; n++) @(posedge mclk) #1;
    chkn(n, 228);
    // Fast PWM pulse width and period, both polarities
    for (k = 2; k < 4; k++) begin
      c = {$random(seed)} % 200;
      wr(2'h2, 8'(c));
      wr(2'h0, {4'h1, 2'(k), 2'h3});
      wait_ocs(n);
      // Align just after a match change, far from the next wrap
      while (ocs !== (k != 2)) wait_ocs(n);
      wr(2'h3, 8'h01);
      chk1(ovf, 1'b0);
      wait_ocs(n);
      chk1(ovf, 1'b1);
      wait_ocs(n);
      wait_ocs(m);
      chkn(n, c + 1);
      chkn(n + m, 256);
    end
    end_sim;
  end
endmodule
`default_nettype wire
